/* core/rpg_sequencer.sv */
// Purpose: Rail enables, timed power sequence, soft start and the
//          delayed power-good output of a four-rail power unit.
// Assumes: Pins and comparator levels are asynchronous; registers
//          are reached over a plain strobe port with 8-bit data.
// Notes:   All slow timers count a 1 us tick from one divider.
`include "rpg_defines.svh"

module rpg_sequencer #(
    parameter int TICK_CYCLES = `RPG_TICK_CYCLES,
    parameter int DEGLITCH_US = `RPG_DEGLITCH_US,
    parameter int MASK_US = `RPG_MASK_US,
    parameter int SS_STEP_US = `RPG_SS_STEP_US
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic buck1_pin_enable,
    input wire logic buck2_pin_enable,
    input wire logic ldo1_pin_enable,
    input wire logic ldo2_pin_enable,
    input wire logic seq_trigger,
    input wire logic raw_input_supply_ok,
    input wire logic buck1_level_ok,
    input wire logic buck2_level_ok,
    input wire logic power_good_n_in,
    output logic power_good_n_out,
    output logic power_good_n_oe,
    output logic buck1_enable_int,
    output logic buck2_enable_int,
    output logic ldo1_enable,
    output logic ldo2_enable,
    output rpg_pkg::rpg_step_t buck1_ss_step,
    output rpg_pkg::rpg_step_t buck2_ss_step,
    output rpg_pkg::rpg_ma_t buck1_ilimit_ma,
    output rpg_pkg::rpg_ma_t buck2_ilimit_ma,
    output logic buck1_discharge,
    output logic buck2_discharge
);
    import rpg_pkg::*;

    logic [5:0] pin_s;  // Synced pins, see grouping below
    logic [2:0] ana_s;  // Synced supply-ok and level-ok
    logic trig_s;       // Synced raw trigger
    logic vin_s;        // Synced supply ok
    logic [1:0] ok_s;   // Synced level-ok per converter
    logic [5:0] tick_cnt;
    logic us_tick;      // One-cycle pulse every microsecond
    logic [15:0] dg_cnt;
    logic trig_f;       // Deglitched trigger
    logic trig_q;
    logic trig_rise;
    logic trig_fall;
    rpg_seq_e seq_state;
    rpg_us_t seq_cnt;
    logic [3:0] seq_en;  // Trigger-driven rail requests
    logic [2:0] seq_code;
    logic [3:0] rail_en;
    logic [1:0] pg_sel;
    logic [3:0] rail_on;
    logic [3:0] rail_q;  // Rail state one cycle back
    rpg_step_t ss [2];
    logic [7:0] ss_cnt [2];
    logic [1:0] ok_q;
    logic released;      // Delay done, power good may show
    logic pg_run;
    rpg_us_t pg_cnt;
    rpg_us_t pg_limit;
    logic mask_run;
    logic [12:0] mask_cnt;
    logic rise_any;
    logic fall_any;

    // Pin and comparator synchronisers; level-ok is the comparator
    // with its own hysteresis band, sampled here
    rpg_sync #(.WIDTH(6)) u_pin_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin({power_good_n_in, seq_trigger, ldo2_pin_enable,
              ldo1_pin_enable, buck2_pin_enable, buck1_pin_enable}),
        .level(pin_s)
    );
    rpg_sync #(.WIDTH(3)) u_ana_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin({buck2_level_ok, buck1_level_ok, raw_input_supply_ok}),
        .level(ana_s)
    );
    assign trig_s = pin_s[4];
    assign vin_s = ana_s[0];
    assign ok_s = ana_s[2:1];

    // Microsecond tick; every slow timer counts it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_cnt <= 6'h0;
            us_tick <= 1'b0;
        end else if (tick_cnt == 6'(TICK_CYCLES - 1)) begin
            tick_cnt <= 6'h0;
            us_tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 6'h1;
            us_tick <= 1'b0;
        end
    end

    // Trigger deglitch: a new level must hold for the full window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dg_cnt <= 16'h0;
            trig_f <= 1'b0;
        end else if (trig_s == trig_f) begin
            dg_cnt <= 16'h0; // Glitch shorter than window is dropped
        end else if (us_tick) begin
            if (dg_cnt == 16'(DEGLITCH_US - 1)) begin
                trig_f <= trig_s;
                dg_cnt <= 16'h0;
            end else begin
                dg_cnt <= dg_cnt + 16'h1;
            end
        end
    end

    // Edge memory for the filtered trigger
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_f;
        end
    end
    assign trig_rise = trig_f & ~trig_q;
    assign trig_fall = ~trig_f & trig_q;

    // Rail delay scaled by code; default code gives nominal times
    function automatic rpg_us_t seq_delay(input logic [1:0] idx,
                                          input logic [2:0] code);
        rpg_us_t nom;
        unique case (idx)
            2'h0: nom = 24'(`RPG_T_BUCK1_US);
            2'h1: nom = 24'(`RPG_T_BUCK2_US);
            2'h2: nom = 24'(`RPG_T_LDO1_US);
            2'h3: nom = 24'(`RPG_T_LDO2_US);
        endcase
        return (nom << code) >> 2;
    endfunction

    // Timed sequence; a new edge restarts it, the host spacing of
    // edges keeps a sequence from being cut short
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_state <= RPG_SEQ_IDLE;
            seq_cnt <= 24'h0;
            seq_en <= 4'h0;
        end else if (trig_rise) begin
            seq_state <= RPG_SEQ_UP;
            seq_cnt <= 24'h0;
        end else if (trig_fall) begin
            seq_state <= RPG_SEQ_DOWN;
            seq_cnt <= 24'h0;
        end else if (us_tick) begin
            unique case (seq_state)
                RPG_SEQ_IDLE: begin
                    seq_cnt <= 24'h0;
                end
                RPG_SEQ_UP, RPG_SEQ_DOWN: begin
                    seq_cnt <= seq_cnt + 24'h1;
                    for (int i = 0; i < 4; i++) begin
                        // Turn-on or turn-off at each rail time
                        if (seq_cnt + 24'h1 == seq_delay(2'(i), seq_code)) begin
                            seq_en[i] <= (seq_state == RPG_SEQ_UP);
                        end
                    end
                    if (seq_cnt + 24'h1 >= seq_delay(2'h3, seq_code)) begin
                        seq_state <= RPG_SEQ_IDLE;
                    end
                end
                default: begin
                    seq_state <= RPG_SEQ_IDLE; // Illegal code recovers
                end
            endcase
        end
    end

    // Register writes; rail enables come up on
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_code <= `RPG_SEQ_CODE_RESET;
            rail_en <= `RPG_RAIL_EN_RESET;
            pg_sel <= `RPG_PG_SEL_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RPG_ADDR_SCR: seq_code <= reg_wdata[`RPG_SEQ_CODE_LSB +: 3];
                `RPG_ADDR_RAIL_EN: rail_en <= reg_wdata[3:0];
                `RPG_ADDR_PG_CTRL: pg_sel <= reg_wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                `RPG_ADDR_SCR: reg_rdata <= {1'b0, seq_code, 4'h0};
                `RPG_ADDR_RAIL_EN: reg_rdata <= {4'h0, rail_en};
                `RPG_ADDR_RAIL_STAT: reg_rdata <= {seq_state != RPG_SEQ_IDLE,
                    trig_f, vin_s, ~power_good_n_oe, rail_on};
                `RPG_ADDR_PG_CTRL: reg_rdata <= {6'h00, pg_sel};
                `RPG_ADDR_LEVEL_STAT: reg_rdata <= {3'h0, pin_s[5],
                    mask_run, pg_run, ok_s};
                default: reg_rdata <= 8'h00; // Unmapped reads zero
            endcase
        end
    end

    // Rail enables; while the trigger is high the pins are not looked
    // at, so only the timed requests steer the rails
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rail_on <= 4'h0;
            rail_q <= 4'h0;
        end else begin
            rail_q <= rail_on;
            for (int i = 0; i < 4; i++) begin
                rail_on[i] <= vin_s & rail_en[i] &
                    (trig_f ? seq_en[i] : (pin_s[i] | seq_en[i]));
            end
        end
    end
    assign buck1_enable_int = rail_on[0];
    assign buck2_enable_int = rail_on[1];
    assign ldo1_enable = rail_on[2];
    assign ldo2_enable = rail_on[3];

    // Soft start per converter; off resets it so re-enable repeats it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < 2; b++) begin
                ss[b] <= 2'h0;
                ss_cnt[b] <= 8'h00;
            end
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (!rail_on[b]) begin
                    ss[b] <= 2'h0;
                    ss_cnt[b] <= 8'h00;
                end else if (!rail_q[b]) begin
                    // Rise can only occur with supply already ok
                    ss[b] <= 2'h1;
                    ss_cnt[b] <= 8'h00;
                end else if (ss[b] != 2'h3 && us_tick) begin
                    if (ss_cnt[b] == 8'(SS_STEP_US - 1)) begin
                        ss[b] <= ss[b] + 2'h1;
                        ss_cnt[b] <= 8'h00;
                    end else begin
                        ss_cnt[b] <= ss_cnt[b] + 8'h01;
                    end
                end
            end
        end
    end
    assign buck1_ss_step = ss[0];
    assign buck2_ss_step = ss[1];

    // Current limit from the step, low-side discharge from the rail enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buck1_ilimit_ma <= 10'h000;
            buck2_ilimit_ma <= 10'h000;
            buck1_discharge <= 1'b1;
            buck2_discharge <= 1'b1;
        end else begin
            unique case (ss[0])
                2'h0: buck1_ilimit_ma <= 10'h000;
                2'h1: buck1_ilimit_ma <= `RPG_B1_ILIM_1;
                2'h2: buck1_ilimit_ma <= `RPG_B1_ILIM_2;
                2'h3: buck1_ilimit_ma <= `RPG_B1_ILIM_3;
            endcase
            unique case (ss[1])
                2'h0: buck2_ilimit_ma <= 10'h000;
                2'h1: buck2_ilimit_ma <= `RPG_B2_ILIM_1;
                2'h2: buck2_ilimit_ma <= `RPG_B2_ILIM_2;
                2'h3: buck2_ilimit_ma <= `RPG_B2_ILIM_3;
            endcase
            buck1_discharge <= ~rail_on[0];
            buck2_discharge <= ~rail_on[1];
        end
    end

    // Selected power-good delay
    always_comb begin
        unique case (pg_sel)
            2'h0: pg_limit = 24'(`RPG_PG_DLY0_US);
            2'h1: pg_limit = 24'(`RPG_PG_DLY1_US);
            2'h2: pg_limit = 24'(`RPG_PG_DLY2_US);
            2'h3: pg_limit = 24'(`RPG_PG_DLY3_US);
        endcase
    end

    // Level edges of enabled converters
    assign rise_any = |(rail_on[1:0] & ok_s & ~ok_q);
    assign fall_any = released & |(rail_on[1:0] & ~ok_s & ok_q);

    // Level history
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ok_q <= 2'h0;
        end else begin
            ok_q <= ok_s;
        end
    end

    // Delay timer; clear wins by priority so set and clear never meet
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            released <= 1'b0;
            pg_run <= 1'b0;
            pg_cnt <= 24'h0;
        end else if (rail_on[1:0] == 2'h0) begin
            released <= 1'b0;
            pg_run <= 1'b0;
            pg_cnt <= 24'h0;
        end else if (fall_any) begin
            released <= 1'b0;
            pg_run <= 1'b1;
            pg_cnt <= 24'h0;
        end else if (!released && !pg_run && rise_any) begin
            pg_run <= 1'b1;
            pg_cnt <= 24'h0;
        end else if (pg_run && us_tick) begin
            // The other converter's rise is not looked at here
            if (pg_cnt == pg_limit - 24'h1) begin
                pg_run <= 1'b0;
                released <= 1'b1;
            end else begin
                pg_cnt <= pg_cnt + 24'h1;
            end
        end
    end

    // Mask window on a late converter enable after release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_run <= 1'b0;
            mask_cnt <= 13'h0;
        end else if (rail_on[1:0] == 2'h0) begin
            mask_run <= 1'b0;
            mask_cnt <= 13'h0;
        end else if (released && |(rail_on[1:0] & ~rail_q[1:0])) begin
            mask_run <= 1'b1;
            mask_cnt <= 13'h0;
        end else if (mask_run && us_tick) begin
            if (mask_cnt == 13'(MASK_US - 1)) begin
                mask_run <= 1'b0;
            end else begin
                mask_cnt <= mask_cnt + 13'h1;
            end
        end
    end

    // Open-drain power good: pull low unless released and levels ok or mask running
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_good_n_out <= 1'b0;
            power_good_n_oe <= 1'b1;
        end else begin
            power_good_n_out <= 1'b0;
            // Enabled one cycle back, so a fresh enable rise waits for
            // its mask flop instead of pulling the wire low
            power_good_n_oe <= ~(released & (mask_run |
                &(ok_s | ~rail_q[1:0])));
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_DEGLITCH: assert property ($changed(trig_f) |->
        $past(dg_cnt) == 16'(DEGLITCH_US - 1) && $past(us_tick))
        else $error("trigger changed before deglitch window");
    AST_SEQ_START: assert property (trig_rise |=>
        seq_state == RPG_SEQ_UP && seq_cnt == 24'h0)
        else $error("rising trigger did not start power-on");
    AST_SEQ_ON: assert property ($rose(seq_en[0]) |->
        $past(seq_state) == RPG_SEQ_UP &&
        $past(seq_cnt) == seq_delay(2'h0, seq_code) - 24'h1)
        else $error("buck1 turn-on at wrong time");
    AST_SEQ_OFF: assert property ($fell(seq_en[3]) |->
        $past(seq_state) == RPG_SEQ_DOWN &&
        $past(seq_cnt) == seq_delay(2'h3, seq_code) - 24'h1)
        else $error("ldo2 turn-off at wrong time");
    AST_VIN_GATE: assert property (!vin_s |=> rail_on == 4'h0)
        else $error("rail on with supply not ok");
    AST_RAIL_EN: assert property ((rail_on & ~$past(rail_en)) == 4'h0)
        else $error("rail on without register enable");
    AST_PIN_IGNORED: assert property (trig_f && $past(trig_f) &&
        $stable(seq_en) && $stable(rail_en) && $stable(vin_s)
        |=> $stable(rail_on))
        else $error("pin toggle changed a rail under trigger");
    AST_SS_FIRST: assert property ($rose(rail_on[0]) |=>
        buck1_ss_step == 2'h1 ##1 buck1_ilimit_ma == `RPG_B1_ILIM_1)
        else $error("soft start did not begin at first step");
    AST_SHUTDOWN: assert property (!rail_on[1] |=>
        buck2_ss_step == 2'h0 && buck2_discharge)
        else $error("disabled buck2 not discharging");
    AST_PG_HOLD: assert property (pg_run |=> power_good_n_oe)
        else $error("power good released during delay");
    AST_RETRIG: assert property (fall_any |=> pg_run && !released)
        else $error("level fall did not retrigger delay");
    AST_MASK: assert property (mask_run && released |=>
        !power_good_n_oe)
        else $error("power good low inside mask window");
    AST_CLEAR: assert property (rail_on[1:0] == 2'h0 |=>
        !released && !pg_run)
        else $error("delay timer not cleared by enables");
    AST_FOLLOW: assert property (released && !mask_run && rail_q[0] &&
        !ok_s[0] |=> power_good_n_oe)
        else $error("power good high with buck1 level low");

    COV_SEQ_DONE: cover property ($fell(seq_en[3]));
    COV_PG_RELEASE: cover property ($fell(power_good_n_oe));
    COV_MASK: cover property ($rose(mask_run));
    COV_SS_TOP: cover property (buck1_ss_step == 2'h3);
endmodule

/* shared/rpg_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts
//          for the regulator sequencer and power-good block.
// Assumes: 50 MHz core clock; times are kept in their own units.
// Notes:   Cycle counts are derived from times, never written twice.
`ifndef RPG_DEFINES_SVH
`define RPG_DEFINES_SVH

// Clock rate and the base tick of every slow timer
`define RPG_CLK_MHZ 50
`define RPG_TICK_US 1
`define RPG_TICK_CYCLES (`RPG_CLK_MHZ * `RPG_TICK_US)

// Trigger deglitch, mask window and soft-start step, in microseconds
`define RPG_DEGLITCH_US 1000
`define RPG_MASK_US 5000
`define RPG_SS_STEP_US 100

// Nominal sequence delays at the default delay code, in microseconds
`define RPG_T_BUCK1_US 1500
`define RPG_T_BUCK2_US 2000
`define RPG_T_LDO1_US 3000
`define RPG_T_LDO2_US 6000

// Power-good delay choices, in microseconds
`define RPG_PG_DLY0_US 50
`define RPG_PG_DLY1_US 50000
`define RPG_PG_DLY2_US 100000
`define RPG_PG_DLY3_US 200000

// Register offsets
`define RPG_ADDR_SCR 8'h07
`define RPG_ADDR_RAIL_EN 8'h10
`define RPG_ADDR_RAIL_STAT 8'h11
`define RPG_ADDR_PG_CTRL 8'h12
`define RPG_ADDR_LEVEL_STAT 8'h13

// Field positions and reset values
`define RPG_SEQ_CODE_LSB 4
`define RPG_SEQ_CODE_RESET 3'h2
`define RPG_RAIL_EN_RESET 4'hF
`define RPG_PG_SEL_RESET 2'h1

// Soft-start switch current limits per step, in mA
`define RPG_B1_ILIM_1 10'h0B4
`define RPG_B1_ILIM_2 10'h12C
`define RPG_B1_ILIM_3 10'h2D0
`define RPG_B2_ILIM_1 10'h0A1
`define RPG_B2_ILIM_2 10'h12C
`define RPG_B2_ILIM_3 10'h218

`endif

/* shared/rpg_pkg.sv */
// Purpose: Types shared by the sequencer and its testbench.
// Assumes: Numbers live in rpg_defines.svh.
// Notes:   Step code 0 means converter off.
package rpg_pkg;
    // Sequence direction
    typedef enum logic [1:0] {
        RPG_SEQ_IDLE = 2'b00,
        RPG_SEQ_UP   = 2'b01,
        RPG_SEQ_DOWN = 2'b10
    } rpg_seq_e;
    // Soft-start step, 0 off, 1..3 current-limit steps
    typedef logic [1:0] rpg_step_t;
    // Current limit in mA
    typedef logic [9:0] rpg_ma_t;
    // Microsecond count
    typedef logic [23:0] rpg_us_t;
endpackage

/* core/rpg_sync.sv */
// Purpose: Three-flop synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to core_clk.
// Notes:   Output moves only when the second and third stages agree.
module rpg_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1; // Metastable stage, read only by s2
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    // Shift chain
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a bit only once two later stages agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    level[i] <= s2[i];
                end
            end
        end
    end
endmodule

/* tb/rpg_host_model.sv */
// Purpose: Host side of the sequencer: pin enables, trigger, pull-up.
// Assumes: Caller runs just after a rising core_clk edge.
// Notes:   Trigger spacing is enforced here, not by the bench.
module rpg_host_model #(
    parameter int FIRST_CYC = 8000,
    parameter int HOLD_CYC = 12000
) (
    input wire logic core_clk,
    input wire logic pg_oe,
    output logic pg_wire,
    output logic seq_trigger,
    output logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0; // Cycles since power-up
    int last = 0; // Cycle of last trigger change
    int lim = FIRST_CYC; // First change waits for supply to settle
    // Converters held off at power-up
    initial begin
        seq_trigger = 1'b0;
        pins = 4'h0;
    end
    // Free cycle count for spacing
    always @(posedge core_clk) cyc <= cyc + 1;
    // Open drain wire with pull-up
    assign pg_wire = pg_oe ? 1'b0 : 1'b1;
    // Trigger change, held off until spacing met
    task automatic set_trig(input logic v);
        while (cyc - last < lim) @(posedge core_clk);
        seq_trigger <= v;
        last = cyc;
        lim = HOLD_CYC;
    endtask
    // Pin enable change on the next edge
    task automatic set_pins(input logic [3:0] v);
        @(posedge core_clk);
        pins <= v;
    endtask
endmodule

/* tb/rpg_sequencer_bench.sv */
// Purpose: Self-checking bench for the rail sequencer.
// Assumes: Timers shortened with one cycle per tick.
// Notes:   Windows allow for pin sync and rail flop lag.
module rpg_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rpg_pkg::*;
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    num_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
    logic core_clk, rst, reg_wr, reg_rd, raw_input_supply_ok;
    logic buck1_level_ok, buck2_level_ok, seq_trigger;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic buck1_pin_enable, buck2_pin_enable;
    logic ldo1_pin_enable, ldo2_pin_enable;
    logic power_good_n_in, power_good_n_out, power_good_n_oe;
    logic buck1_enable_int, buck2_enable_int, ldo1_enable, ldo2_enable;
    logic buck1_discharge, buck2_discharge;
    rpg_step_t buck1_ss_step, buck2_ss_step;
    rpg_ma_t buck1_ilimit_ma, buck2_ilimit_ma;
    logic [3:0] pins; // Host pin enables
    logic [4:0] mon; // Watched levels: wire, then rails
    logic [1:0] ok_req; // Converter outputs asked to reach level
    int num_errors = 0;
    int num_checks = 0;
    assign {ldo2_pin_enable, ldo1_pin_enable} = pins[3:2];
    assign {buck2_pin_enable, buck1_pin_enable} = pins[1:0];
    // A converter reaches its level only while it is enabled
    assign {buck2_level_ok, buck1_level_ok} = ok_req &
        {buck2_enable_int, buck1_enable_int};
    assign mon = {power_good_n_in, ldo2_enable, ldo1_enable,
                  buck2_enable_int, buck1_enable_int};
    rpg_sequencer #(.TICK_CYCLES(1), .DEGLITCH_US(4), .MASK_US(8),
        .SS_STEP_US(4)) dut (.*);
    rpg_host_model host (.core_clk(core_clk), .pg_oe(power_good_n_oe),
        .pg_wire(power_good_n_in), .seq_trigger(seq_trigger), .pins(pins));
    // Clock, 20 ns period
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data valid only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK("reg", e, reg_rdata)
        @(posedge core_clk);
    endtask
    // Bounded wait for a watched level
    task automatic wait_mon(input int i, input logic v, output int n);
        n = 0;
        while (mon[i] !== v && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic t_reset;
        `CHK("disch", 1'b1, buck1_discharge)
        `CHK("pgout", 1'b0, power_good_n_out)
        chk_reg(8'h07, 8'h20);
        wr(8'h07, 8'h30);
        chk_reg(8'h07, 8'h30);
        wr(8'h07, 8'h20);
        chk_reg(8'h10, 8'h0F);
        chk_reg(8'h12, 8'h01);
        chk_reg(8'h30, 8'h00);
        wr(8'h11, 8'hFF);
        chk_reg(8'h11, 8'h20);
    endtask
    // Soft start steps of one converter
    task automatic t_ss(input int i);
        rpg_ma_t lim[2][3] = '{'{10'h0B4, 10'h12C, 10'h2D0},
                               '{10'h0A1, 10'h12C, 10'h218}};
        rpg_ma_t m, prev;
        int n;
        prev = '0;
        host.set_pins(4'(1 << i));
        wait_mon(i, 1'b1, n);
        `CHK("on", 1, n < 12)
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge core_clk);
                #1 m = i ? buck2_ilimit_ma : buck1_ilimit_ma;
                n++;
            end while (m === prev && n < 50);
            `CHK("ilim", lim[i][k], m)
            prev = m;
        end
        `CHK("step", 2'h3, i ? buck2_ss_step : buck1_ss_step)
        `CHK("dis", 1'b0, i ? buck2_discharge : buck1_discharge)
        host.set_pins(4'h0);
        wait_mon(i, 1'b0, n);
        repeat (3) @(posedge core_clk);
        `CHK("dis", 1'b1, i ? buck2_discharge : buck1_discharge)
    endtask
    // Register and supply gating, then power-good timing
    task automatic t_gate_pg;
        int n;
        host.set_pins(4'h1);
        wait_mon(0, 1'b1, n);
        wr(8'h10, 8'h0E);
        wait_mon(0, 1'b0, n);
        `CHK("regoff", 1, n < 4)
        wr(8'h10, 8'h0F);
        wait_mon(0, 1'b1, n);
        raw_input_supply_ok <= 1'b0;
        wait_mon(0, 1'b0, n);
        `CHK("uvlo", 1, n < 10)
        raw_input_supply_ok <= 1'b1;
        wait_mon(0, 1'b1, n);
        wr(8'h12, 8'h00);
        ok_req[0] <= 1'b1;
        wait_mon(4, 1'b1, n);
        `CHK("pgdly", 1, n >= 50 && n < 64)
        ok_req[0] <= 1'b0;
        wait_mon(4, 1'b0, n);
        `CHK("pglow", 1, n < 10)
        ok_req[0] <= 1'b1;
        wait_mon(4, 1'b1, n);
        `CHK("retrig", 1, n >= 50 && n < 64)
        host.set_pins(4'h3);
        wait_mon(4, 1'b0, n);
        `CHK("mask", 1, n >= 8 && n < 24)
        ok_req[1] <= 1'b1;
        wait_mon(4, 1'b1, n);
        `CHK("follow", 1, n < 10)
        ok_req <= 2'b00;
        host.set_pins(4'h0);
        wait_mon(1, 1'b0, n);
    endtask
    // Timed power-on and power-off, pins ignored while trigger high
    task automatic t_seq;
        int d[4] = '{1500, 2000, 3000, 6000};
        int n, t;
        for (int v = 1; v >= 0; v--) begin
            host.set_trig(v[0]);
            t = 0;
            for (int i = 0; i < 4; i++) begin
                wait_mon(i, v[0], n);
                t += n;
                `CHK("seq", 1, t >= d[i] && t <= d[i] + 16)
                if (v == 1 && i == 0) begin
                    host.set_pins(4'hE);
                    repeat (10) @(posedge core_clk);
                    #1 `CHK("pins", 4'h1, mon[3:0])
                    host.set_pins(4'h0);
                    t += 12;
                end
            end
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, ok_req} = 4'h0;
        {reg_addr, reg_wdata} = 16'h0000;
        raw_input_supply_ok = 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_ss(0);
        t_ss(1);
        t_gate_pg();
        t_seq();
        final_report();
    end
    // Watchdog well past the longest expected run
    initial begin
        #1_000_000;
        num_errors++;
        final_report();
    end
endmodule
